// ### design/sec_pkg.sv
/*
  Package for the sector check-code and burst-trap unit: register offsets,
  field positions, reset values and cycle counts.
  Assumes a single 50 MHz clock and a plain strobe register port.
*/
package sec_pkg;
  // register offsets
  localparam logic [3:0] ADDR_ERR1    = 4'h0;
  localparam logic [3:0] ADDR_OFFSET  = 4'h1;
  localparam logic [3:0] ADDR_STATUS  = 4'h2;
  localparam logic [3:0] ADDR_PATTERN = 4'h3;
  localparam logic [3:0] ADDR_POS     = 4'h4;
  localparam logic [3:0] ADDR_CTRL    = 4'h5;
  // field positions
  localparam int ERR1_DCK_BIT   = 15;
  localparam int ERR1_UNC_BIT   = 14;
  localparam int OFS_ECI_BIT    = 11;
  localparam int STAT_CERR_BIT  = 14;
  localparam int STAT_DONE_BIT  = 7;
  localparam int STAT_BUSY_BIT  = 6;
  localparam int CTRL_FMT18_BIT = 0;
  localparam int CTRL_CLR_BIT   = 1;
  // check register geometry
  localparam int CHK_W     = 32;
  localparam int ZERO_W    = 21;
  localparam int BURST_W   = 11;
  localparam int MSB_BIT   = 31;
  localparam logic [31:0] CHK_POLY  = 32'h00a00805;
  localparam logic [31:0] CHK_RESET = 32'h00000000;
  // counts
  localparam int CNT_W = 14;
  localparam logic [13:0] HARD_CNT_16 = 14'd4128;
  localparam logic [13:0] HARD_CNT_18 = 14'd4640;
  localparam logic [13:0] LEAD_ZEROS_16 = 14'h0040;
  localparam logic [13:0] LEAD_ZEROS_18 = 14'h0040;
  localparam logic [15:0] REG_RESET = 16'h0000;
endpackage : sec_pkg

// ### design/sec_burst_corrector.sv
/*
  Sector check-code unit: builds the 32-bit check field on writes, checks
  it on reads, and traps an 11-bit burst on a data check.
  Assumes window and command inputs synchronous to ref_clk, one bit per
  clock while a window is open, and software reads over a strobe port.
*/
// How it works
// - write builds 32-bit code over 256-word data, sent right after data.
// - write with data window enables feedback, each sent bit enters register.
// - check window on write: flop follows bit 31 to form check output.
// - read with data window enables feedback, each read bit enters register.
// - on a read, check window follows data window, keeping feedback on for check bits.
// - low 21 bits zero at check end: syndrome zero, normal end-of-block.
// - nonzero syndrome at check end sets data check flag, error bit 15.
// - data check sets composite error, which raises attention.
// - data check holds end-of-block until correction finishes.
// - correction inhibit sends end-of-block and skips correction.
// - data check without inhibit starts correction and the bit counter.
// - after leading-zero shifts, field entry enables position and detect.
// - position counts each data bit shifted after field entry.
// - low 21 zero during correction ends it; position holds burst start.
// - done freezes register so 11 pattern bits stay readable.
// - done forces end-of-block to the controller.
// - burst detection stops the position counter.
// - count 4128 or 4640 after entry without zeros sets uncorrectable.
// - burst pattern and position readable by software.
module sec_burst_corrector #(
  parameter logic [13:0] LEAD_16 = sec_pkg::LEAD_ZEROS_16,
  parameter logic [13:0] LEAD_18 = sec_pkg::LEAD_ZEROS_18
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // sector sequencing
  input  wire logic        write_cmd_active,
  input  wire logic        read_cmd_active,
  input  wire logic        data_window,
  input  wire logic        check_window,
  input  wire logic        serial_bit_in,
  // controller side
  output logic             check_bits_out,
  output logic             sector_end_signal,
  output logic             attention,
  output logic             data_check_flag,
  output logic             uncorrectable_flag,
  output logic             correction_done,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata
);

  typedef enum logic [2:0] {
    SEC_IDLE, SEC_DATA, SEC_CHECK, SEC_CORR, SEC_END
  } sec_state_e;

  sec_state_e           state;
  logic [31:0]          chk;
  logic [13:0]          bit_cnt;
  logic [13:0]          pos_cnt;
  logic                 field_entry;
  logic                 correction_active;
  logic                 correction_inhibit;
  logic                 fmt18;
  logic                 data_win_q;
  logic                 check_win_q;
  logic                 composite_err;
  logic                 feedback_enable;
  logic                 syndrome_zero;
  logic                 data_start;
  logic                 check_end;
  logic                 hard_error_detect;
  logic                 set_data_check;
  logic                 sw_clear;
  logic [13:0]          lead_cnt;
  logic [13:0]          hard_cnt;
  logic                 corr_end;

  // one feedback step of the check register
  function automatic logic [31:0] chk_step(input logic [31:0] r,
                                           input logic        b);
    logic fb;
    fb = r[sec_pkg::MSB_BIT] ^ b;
    chk_step = {r[30:0], 1'b0} ^ (fb ? sec_pkg::CHK_POLY : 32'h00000000);
  endfunction : chk_step

  // a trapped burst or the hard limit both close the correction pass
  function automatic logic corr_finish(input logic entered,
                                       input logic zero,
                                       input logic hard);
    corr_finish = (entered & zero) | hard;
  endfunction : corr_finish

  assign data_start = data_window & ~data_win_q;
  assign check_end  = check_win_q & ~check_window;
  assign sw_clear   = reg_wr & (reg_addr == sec_pkg::ADDR_CTRL) &
                      reg_wdata[sec_pkg::CTRL_CLR_BIT];
  // zero detect
  // only the low 21 bits are watched; the 11 high bits carry the burst
  assign syndrome_zero = (chk[sec_pkg::ZERO_W-1:0] == 21'h000000);
  assign lead_cnt = fmt18 ? LEAD_18 : LEAD_16;
  assign hard_cnt = fmt18 ? sec_pkg::HARD_CNT_18 : sec_pkg::HARD_CNT_16;
  // feedback gating
  // the state test keeps idle line noise out of the register between sectors
  assign feedback_enable = ((write_cmd_active | read_cmd_active) &
                            (data_window | check_window) &
                            (state == SEC_DATA || state == SEC_CHECK)) |
                           correction_active;
  assign set_data_check = read_cmd_active & check_end & ~syndrome_zero &
                          (state == SEC_CHECK);
  // hard limit after field entry
  // counted from entry, so a long lead-zero run does not eat into the limit
  assign hard_error_detect = correction_active & field_entry &
                             (pos_cnt >= hard_cnt) & ~syndrome_zero;
  assign corr_end = corr_finish(field_entry, syndrome_zero,
                                hard_error_detect);

  // window edges are found against the previous sample of each window
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_win_q  <= 1'b0;
      check_win_q <= 1'b0;
    end else begin
      data_win_q  <= data_window;
      check_win_q <= check_window;
    end
  end

  // sequencing
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= SEC_IDLE;
    end else if (data_start) begin
      state <= SEC_DATA;
    end else begin
      case (state)
        SEC_IDLE: state <= SEC_IDLE;
        SEC_DATA: begin
          if (check_window) begin
            state <= SEC_CHECK;
          end
        end
        SEC_CHECK: begin
          if (check_end) begin
            if (set_data_check && !correction_inhibit) begin
              state <= SEC_CORR;
            end else begin
              state <= SEC_END;
            end
          end
        end
        SEC_CORR: begin
          if (corr_end) begin
            state <= SEC_END;
          end
        end
        SEC_END: state <= SEC_END;
        default: state <= SEC_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      chk <= sec_pkg::CHK_RESET;
    end else if (data_start) begin
      chk <= chk_step(sec_pkg::CHK_RESET, serial_bit_in);
    end else if (correction_done) begin
      chk <= chk;
    end else if (correction_active) begin
      chk <= chk_step(chk, 1'b0);
    end else if (feedback_enable && (read_cmd_active || data_window)) begin
      chk <= chk_step(chk, serial_bit_in);
    end else if (feedback_enable && write_cmd_active) begin
      // a write shifts the code out msb first instead of feeding it back
      chk <= {chk[30:0], 1'b0};
    end
  end

  // check field output flop
  // gated by the window so the pin rests low between check fields
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      check_bits_out <= 1'b0;
    end else begin
      check_bits_out <= write_cmd_active & check_window &
                        chk[sec_pkg::MSB_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      correction_active <= 1'b0;
    end else if (data_start) begin
      correction_active <= 1'b0;
    end else if (state == SEC_CHECK && check_end && set_data_check &&
                 !correction_inhibit) begin
      correction_active <= 1'b1;
    end else if (corr_end) begin
      correction_active <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt <= 14'h0000;
    end else if (data_start) begin
      bit_cnt <= 14'h0000;
    end else if (correction_active && !field_entry) begin
      bit_cnt <= bit_cnt + 14'h0001;
    end
  end

  // field entry
  // entry is sticky, so the counter freezes at the lead count and cannot wrap
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      field_entry <= 1'b0;
    end else if (data_start) begin
      field_entry <= 1'b0;
    end else if (correction_active && !field_entry &&
                 (bit_cnt + 14'h0001 >= lead_cnt)) begin
      field_entry <= 1'b1;
    end
  end

  // position counter
  // counted from field entry, so it reads as a bit offset into the data
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_cnt <= 14'h0000;
    end else if (data_start) begin
      pos_cnt <= 14'h0000;
    end else if (correction_active && field_entry && !syndrome_zero &&
                 !hard_error_detect) begin
      pos_cnt <= pos_cnt + 14'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      correction_done <= 1'b0;
    end else if (data_start) begin
      correction_done <= 1'b0;
    end else if (correction_active && field_entry && syndrome_zero) begin
      correction_done <= 1'b1;
    end
  end

  // end-of-block pulse
  // a held data check is released only by the trap or the hard limit
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sector_end_signal <= 1'b0;
    end else if (data_start) begin
      sector_end_signal <= 1'b0;
    end else if (correction_active && field_entry && syndrome_zero) begin
      sector_end_signal <= 1'b1;
    end else if (hard_error_detect) begin
      sector_end_signal <= 1'b1;
    end else if (state == SEC_CHECK && check_end) begin
      sector_end_signal <= ~set_data_check | correction_inhibit;
    end else begin
      sector_end_signal <= 1'b0;
    end
  end

  // data check, set wins over software clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_check_flag <= 1'b0;
    end else if (set_data_check) begin
      data_check_flag <= 1'b1;
    end else if (data_start || sw_clear) begin
      data_check_flag <= 1'b0;
    end
  end

  // hard error, set wins over software clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      uncorrectable_flag <= 1'b0;
    end else if (hard_error_detect) begin
      uncorrectable_flag <= 1'b1;
    end else if (data_start || sw_clear) begin
      uncorrectable_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      composite_err <= 1'b0;
      attention     <= 1'b0;
    end else begin
      if (set_data_check || hard_error_detect) begin
        composite_err <= 1'b1;
      end else if (sw_clear) begin
        composite_err <= 1'b0;
      end
      // the raw events pass straight through, so attention rises in the same cycle as the flag
      attention <= composite_err | set_data_check | hard_error_detect;
    end
  end

  // software control bits
  // not guarded against a change in mid-correction: the lead and hard
  // counts follow the format bit at once
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      correction_inhibit <= 1'b0;
      fmt18              <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == sec_pkg::ADDR_OFFSET) begin
        correction_inhibit <= reg_wdata[sec_pkg::OFS_ECI_BIT];
      end
      if (reg_addr == sec_pkg::ADDR_CTRL) begin
        fmt18 <= reg_wdata[sec_pkg::CTRL_FMT18_BIT];
      end
    end
  end

  // register read-back, data valid one cycle after strobe
  // zero outside the answer cycle, so a late sample shows nothing stale
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= sec_pkg::REG_RESET;
    end else if (reg_rd) begin
      case (reg_addr)
        sec_pkg::ADDR_ERR1:
          reg_rdata <= {data_check_flag, uncorrectable_flag, 14'h0000};
        sec_pkg::ADDR_OFFSET:
          reg_rdata <= {4'h0, correction_inhibit, 11'h000};
        sec_pkg::ADDR_STATUS:
          reg_rdata <= {1'b0, composite_err, 6'h00, correction_done,
                        correction_active, 6'h00};
        sec_pkg::ADDR_PATTERN:
          reg_rdata <= {5'h00, chk[31:21]};
        sec_pkg::ADDR_POS:
          reg_rdata <= {2'b00, pos_cnt};
        sec_pkg::ADDR_CTRL:
          reg_rdata <= {15'h0000, fmt18};
        default:
          reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule : sec_burst_corrector

// ### sim/sec_burst_corrector_asserts.sv
/*
  Port checker for the sector check-code unit.
  Assumes it is bound to the top module and sees its ports only.
*/
module sec_asserts (
  // watched ports
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic       write_cmd_active,
  input wire logic       check_window,
  input wire logic       data_window,
  input wire logic       reg_wr,
  input wire logic [3:0] reg_addr,
  input wire logic       check_bits_out,
  input wire logic       sector_end_signal,
  input wire logic       attention,
  input wire logic       data_check_flag,
  input wire logic       uncorrectable_flag,
  input wire logic       correction_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_out_src;
    check_bits_out |-> $past(write_cmd_active & check_window);
  endproperty
  a_out_src: assert property (p_out_src)
    else $error("check output outside a write check field");
  property p_end_one;
    sector_end_signal |=> !sector_end_signal;
  endproperty
  a_end_one: assert property (p_end_one)
    else $error("end of block longer than one cycle");
  property p_attn;
    $rose(data_check_flag) |-> ##[0:2] attention;
  endproperty
  a_attn: assert property (p_attn)
    else $error("attention missing after data check");
  property p_dck_hold;
    data_check_flag && !data_window
      && !(reg_wr && reg_addr == sec_pkg::ADDR_CTRL) |=> data_check_flag;
  endproperty
  a_dck_hold: assert property (p_dck_hold)
    else $error("data check flag dropped");
  property p_done_end;
    $rose(correction_done) |->
      $past(sector_end_signal) or ##[0:2] sector_end_signal;
  endproperty
  a_done_end: assert property (p_done_end)
    else $error("no end of block on burst trap");
  property p_unc_end;
    $rose(uncorrectable_flag) |->
      $past(sector_end_signal) or ##[0:2] sector_end_signal;
  endproperty
  a_unc_end: assert property (p_unc_end)
    else $error("no end of block on hard error");
  property p_excl;
    correction_done |-> !uncorrectable_flag;
  endproperty
  a_excl: assert property (p_excl)
    else $error("hard error after burst trap");
  property p_done_dck;
    correction_done |-> data_check_flag;
  endproperty
  a_done_dck: assert property (p_done_dck)
    else $error("burst trap without data check");
endmodule : sec_asserts

// ### sim/sec_ctl_model.sv
/*
  Disk controller model: frames one sector onto the serial input and
  keeps the check bits a write sends back. Assumes one bit per clock.
*/
module sec_ctl_model #(
  parameter int NBITS = 4096
) (
  // clock
  input  wire logic ref_clk,
  // frame drive
  output logic      write_cmd_active,
  output logic      read_cmd_active,
  output logic      data_window,
  output logic      check_window,
  output logic      serial_bit_in,
  // returned check field
  input  wire logic check_bits_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        frame_bit = 1'b0;
  logic        in_frame  = 1'b0;
  logic        idle_bit  = 1'b0;
  logic        cw_q      = 1'b0;
  logic [31:0] cap       = 32'h00000000;
  // idle line toggles so a stale bit never passes for data
  assign serial_bit_in = in_frame ? frame_bit : idle_bit;
  initial begin
    write_cmd_active = 1'b0;
    read_cmd_active  = 1'b0;
    data_window      = 1'b0;
    check_window     = 1'b0;
  end
  always @(posedge ref_clk) begin
    idle_bit <= ~idle_bit;
    cw_q     <= write_cmd_active & check_window;
    if (cw_q) begin
      cap <= {cap[30:0], check_bits_out};
    end
  end
  // flip < 0 sends the sector unharmed
  task automatic run_sector(input logic wr, input int flip);
    logic b;
    @(posedge ref_clk);
    write_cmd_active <= wr;
    read_cmd_active  <= ~wr;
    for (int i = 0; i < NBITS + 32; i++) begin
      @(posedge ref_clk);
      b = (i < NBITS) ? (i[0] ^ i[3] ^ i[7]) : cap[NBITS + 31 - i];
      in_frame  <= 1'b1;
      frame_bit <= b ^ (i == flip);
      data_window  <= (i < NBITS);
      check_window <= (i >= NBITS);
    end
    @(posedge ref_clk);
    in_frame     <= 1'b0;
    data_window  <= 1'b0;
    check_window <= 1'b0;
  endtask : run_sector
endmodule : sec_ctl_model

// ### sim/sec_burst_corrector_tb.sv
/*
  Bench for the sector check-code unit: sectors through the controller
  model, results over the register port. Assumes 16-bit format.
*/
module sec_burst_corrector_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        arst_n  = 1'b0;
  logic        write_cmd_active, read_cmd_active, data_window;
  logic        check_window, serial_bit_in, check_bits_out;
  logic        sector_end_signal, attention, data_check_flag;
  logic        uncorrectable_flag, correction_done, seen;
  logic [3:0]  reg_addr  = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [15:0] reg_rdata, rv, rv2;
  int          err_total  = 0;
  int          num_checks = 0;
  // short leading-zero run keeps correction quick
  sec_burst_corrector #(.LEAD_16(14'h0008), .LEAD_18(14'h0008)) dut (
    .ref_clk, .arst_n, .write_cmd_active, .read_cmd_active, .data_window,
    .check_window, .serial_bit_in, .check_bits_out, .sector_end_signal,
    .attention, .data_check_flag, .uncorrectable_flag, .correction_done,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  sec_ctl_model #(.NBITS(4096)) u_ctl (
    .ref_clk, .write_cmd_active, .read_cmd_active, .data_window,
    .check_window, .serial_bit_in, .check_bits_out);
  initial forever #10 ref_clk = ~ref_clk;
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk16
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read
  // a required end that never comes closes the run
  task automatic wait_end(input int lim, input logic must, output logic s);
    s = 1'b0;
    for (int i = 0; i < lim && !s; i++) begin
      @(posedge ref_clk);
      #1 s = (sector_end_signal === 1'b1);
    end
    if (must && !s) begin
      err_total++;
      $display("Error at %0t: no end of block", $time);
      final_report();
    end
  endtask : wait_end
  initial begin
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    reg_read(sec_pkg::ADDR_ERR1, rv);
    chk16(rv, sec_pkg::REG_RESET);
    reg_read(4'hf, rv);
    chk16(rv, 16'h0000);
    u_ctl.run_sector(1'b1, -1);
    u_ctl.run_sector(1'b0, 100);
    wait_end(6, 1'b0, seen);
    chk1(seen, 1'b0);
    chk1(data_check_flag, 1'b1);
    chk1(attention, 1'b1);
    reg_read(sec_pkg::ADDR_ERR1, rv);
    chk1(rv[sec_pkg::ERR1_DCK_BIT], 1'b1);
    wait_end(4400, 1'b1, seen);
    repeat (2) @(posedge ref_clk);
    #1 chk1(correction_done ^ uncorrectable_flag, 1'b1);
    if (correction_done === 1'b1) begin
      reg_read(sec_pkg::ADDR_PATTERN, rv);
      chk1(|rv[10:0], 1'b1);
      repeat (20) @(posedge ref_clk);
      reg_read(sec_pkg::ADDR_PATTERN, rv2);
      chk16(rv2, rv);
      reg_read(sec_pkg::ADDR_POS, rv);
      chk1(rv[13:0] < 14'd4128, 1'b1);
    end else begin
      reg_read(sec_pkg::ADDR_ERR1, rv);
      chk1(rv[sec_pkg::ERR1_UNC_BIT], 1'b1);
    end
    u_ctl.run_sector(1'b0, -1);
    wait_end(6, 1'b1, seen);
    chk1(data_check_flag, 1'b0);
    chk1(correction_done, 1'b0);
    reg_write(sec_pkg::ADDR_OFFSET, 16'h0800);
    reg_read(sec_pkg::ADDR_OFFSET, rv);
    chk16(rv, 16'h0800);
    u_ctl.run_sector(1'b0, 300);
    wait_end(6, 1'b1, seen);
    @(posedge ref_clk);
    #1 chk1(data_check_flag, 1'b1);
    repeat (200) @(posedge ref_clk);
    #1 chk1(correction_done, 1'b0);
    // software clear drops the flags and selects the long format
    reg_write(sec_pkg::ADDR_CTRL, 16'h0003);
    reg_read(sec_pkg::ADDR_CTRL, rv);
    chk16(rv, 16'h0001);
    chk1(data_check_flag, 1'b0);
    chk1(attention, 1'b0);
    final_report();
  end
endmodule : sec_burst_corrector_tb
bind sec_burst_corrector sec_asserts u_chk (
  .ref_clk, .arst_n, .write_cmd_active, .check_window, .data_window,
  .reg_wr, .reg_addr, .check_bits_out, .sector_end_signal, .attention,
  .data_check_flag, .uncorrectable_flag, .correction_done);
